// file: logic/crh_defs.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * codec reset, calibration and hold sequencer.
 * Assumes a 40 MHz reference clock; included by bare name.
 */
`ifndef CRH_DEFS_SVH
`define CRH_DEFS_SVH

// ****************************************
// Register indices
// ****************************************
`define CRH_ADDR_RSVD 5'h00
`define CRH_ADDR_CLKMODE 5'h01
`define CRH_ADDR_CONV 5'h02
`define CRH_ADDR_DACCTL 5'h03
`define CRH_ADDR_INCTL 5'h0c
`define CRH_ADDR_AUXCTL 5'h0e

// ****************************************
// Reset values
// ****************************************
`define CRH_RST_RSVD 8'h00
`define CRH_RST_PTR 8'h01
`define CRH_RST_CLKMODE 8'h01
`define CRH_RST_CONV 8'h01
`define CRH_RST_DACCTL 8'h3f
`define CRH_RST_INCTL 8'h00
`define CRH_RST_AUXCTL 8'h00

// ****************************************
// Field positions and write masks
// ****************************************
`define CRH_PTR_STEP_BIT 7
`define CRH_PTR_WMASK 8'h9f
`define CRH_CLKMODE_WMASK 8'h7f
`define CRH_CLKMODE_SRC_MSB 2
`define CRH_CLKMODE_XTAL_MSB 4
`define CRH_CONV_HOLD_BIT 0
`define CRH_CONV_CALREQ_BIT 1
`define CRH_CONV_LOOPI_BIT 3
`define CRH_CONV_DU_BIT 5
`define CRH_CONV_CLKE_BIT 6
`define CRH_CONV_TRIM_BIT 7
`define CRH_CONV_WMASK 8'h0b
`define CRH_DAC_MUTE_ALL 6'h3f
`define CRH_INCTL_VALID_BIT 6
`define CRH_INCTL_BIPH_BIT 5
`define CRH_INCTL_PAR_BIT 4
`define CRH_AUX_SRC_MSB 2
`define CRH_AUX_SOFT_BIT 3
`define CRH_AUX_WIDTH_BIT 4
`define CRH_AUX_MUTEAFTER_BIT 5
`define CRH_AUX_AUTOUNMUTE_BIT 6
`define CRH_AUX_WMASK 8'h7f
`define CRH_SRC_RX_FIRST 3'h4
`define CRH_DEEMPH_SOFT_LAST 3'h3
`define CRH_DEEMPH_CHSTAT 3'h7

// ****************************************
// Rates and de-emphasis widths
// ****************************************
`define CRH_RATE_44K 2'h0
`define CRH_RATE_48K 2'h1
`define CRH_RATE_RSVD 2'h2
`define CRH_RATE_32K 2'h3
`define CRH_MASK_ALL24 24'hffffff
`define CRH_MASK_AUDIO20 24'hfffff0

// ****************************************
// Timing
// ****************************************
`define CRH_CLK_PERIOD_NS 25
`define CRH_MCLK_LOSS_NS 10000
`define CRH_MCLK_LOSS_CYC (`CRH_MCLK_LOSS_NS / `CRH_CLK_PERIOD_NS)
`define CRH_CAL_MS 50
`define CRH_CAL_CYC (`CRH_CAL_MS * 1000000 / `CRH_CLK_PERIOD_NS)
`define CRH_HOLD_MUTE_LIMIT 15

`endif

// file: logic/crh_pkg.sv
/*
 * Types of the reset, calibration and hold sequencer.
 * Assumes crh_defs.svh for all numeric constants.
 */
package crh_pkg;

    typedef logic [7:0] crh_byte_t;

    typedef enum logic [4:0] {
        CRH_PWRDN = 5'b00001,
        CRH_HOLDRST = 5'b00010,
        CRH_CALIB = 5'b00100,
        CRH_RUN = 5'b01000,
        CRH_STBY = 5'b10000
    } crh_state_t;

endpackage : crh_pkg

// file: logic/crh_cal_if.sv
/*
 * Start, abort, busy and done between the sequencer and its
 * calibration timer. Assumes both ends on ref_clk.
 */
`timescale 1ns/100ps
interface crh_cal_if;
    logic start;
    logic abort;
    logic busy;
    logic done;
    modport ctl (output start, output abort, input busy, input done);
    modport tmr (input start, input abort, output busy, output done);
endinterface : crh_cal_if

// file: logic/crh_cal_timer.sv
/*
 * Offset calibration timer: a start pulse (re)loads the count, done pulses
 * at the end. Assumes start and abort are one-cycle pulses on ref_clk.
 */
`timescale 1ns/100ps
`include "crh_defs.svh"
module crh_cal_timer #(
    parameter int CAL_CYCLES = `CRH_CAL_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    // Control side
    crh_cal_if.tmr cal
);
    import crh_pkg::*;

    localparam int CW = $clog2(CAL_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CAL_CYCLES - 1);

    logic [CW-1:0] count_q;
    logic busy_q;
    logic done_q;

    assign cal.busy = busy_q;
    assign cal.done = done_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (ce) begin
            done_q <= 1'b0;
            if (cal.abort) begin
                busy_q <= 1'b0;
            end else if (cal.start) begin
                // A new request restarts the full cycle
                count_q <= LOAD;
                busy_q <= 1'b1;
            end else if (busy_q) begin
                if (count_q == '0) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end else begin
                    count_q <= count_q - 1'b1;
                end
            end
        end
    end

endmodule : crh_cal_timer

// file: logic/crh_seq_top.sv
/*
 * Codec reset, stand-by, calibration, de-emphasis selection and sample
 * hold sequencer with its control registers.
 * Assumes control-port strobes arrive decoded on ref_clk; receiver error
 * and channel-status inputs are on ref_clk; other pins are asynchronous.
 */
`timescale 1ns/100ps
`include "crh_defs.svh"

module crh_seq_top #(
    parameter int CAL_CYCLES = `CRH_CAL_CYC,
    parameter int MCLK_LOSS_CYC = `CRH_MCLK_LOSS_CYC,
    parameter int HOLD_LIMIT = `CRH_HOLD_MUTE_LIMIT
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    // Asynchronous pins
    input wire logic powerDownPinN,
    input wire logic masterClkPin,
    input wire logic frameSyncClock,
    input wire logic frameSyncMatch,
    input wire logic pllLockPin,
    input wire logic freezePin,
    input wire logic deemphPin,
    // Receiver, on ref_clk
    input wire logic parityErr,
    input wire logic biphaseErr,
    input wire logic validityErr,
    input wire logic chStatEmphasis,
    input wire logic [1:0] rxRate,
    input wire logic rxRateValid,
    // Control port, decoded strobes
    input wire logic ctlPtrWr,
    input wire logic ctlDataWr,
    input wire logic ctlDataRd,
    input wire crh_pkg::crh_byte_t ctlWrData,
    output crh_pkg::crh_byte_t ctlRdData_q,
    // Core controls
    output crh_pkg::crh_state_t coreState_q,
    output logic commonModeEn_q,
    output logic coreRun_q,
    output logic standby_q,
    output logic loopCurrentHigh_q,
    // De-emphasis
    output logic deemphOn_q,
    output logic [1:0] deemphRate_q,
    output logic [23:0] deemphMask_q,
    // Hold and mute
    output logic sampleHold_q,
    output logic auxDiscard_q,
    output logic [5:0] dacMute_q
);
    import crh_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int NPIN = 7;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinMeta_q;
    logic [NPIN-1:0] pinSync_q;
    assign pinRaw = {deemphPin, freezePin, pllLockPin, frameSyncMatch,
                     frameSyncClock, masterClkPin, powerDownPinN};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    pinMeta_q[gi] <= 1'b0;
                    pinSync_q[gi] <= 1'b0;
                end else if (ce) begin
                    pinMeta_q[gi] <= pinRaw[gi];
                    pinSync_q[gi] <= pinMeta_q[gi];
                end
            end
        end
    endgenerate

    logic pdnLow;
    logic fsyncOk;
    logic pllLocked;
    logic freezeIn;
    logic deemphIn;
    logic mclkPrev_q;
    logic fsyncPrev_q;
    logic lockPrev_q;
    logic mclkEdge;
    logic frameEdge;
    assign pdnLow = !pinSync_q[0];
    assign fsyncOk = pinSync_q[3];
    assign pllLocked = pinSync_q[4];
    assign freezeIn = pinSync_q[5];
    assign deemphIn = pinSync_q[6];
    assign mclkEdge = pinSync_q[1] ^ mclkPrev_q;
    assign frameEdge = pinSync_q[2] & !fsyncPrev_q;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mclkPrev_q <= 1'b0;
            fsyncPrev_q <= 1'b0;
            lockPrev_q <= 1'b0;
        end else if (ce) begin
            mclkPrev_q <= pinSync_q[1];
            fsyncPrev_q <= pinSync_q[2];
            lockPrev_q <= pllLocked;
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    crh_byte_t ptr_q;
    crh_byte_t rsvd_q;
    crh_byte_t clkMode_q;
    crh_byte_t conv_q;
    crh_byte_t dacCtl_q;
    crh_byte_t inCtl_q;
    crh_byte_t auxCtl_q;
    logic [4:0] idx;
    logic dataWr;
    logic calBusy;
    logic clkFault;
    logic holdEnd;
    logic autoMute_q;
    assign idx = ptr_q[4:0];
    assign dataWr = ctlDataWr && !pdnLow;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= `CRH_RST_PTR;
        end else if (ce) begin
            if (pdnLow) begin
                ptr_q <= `CRH_RST_PTR;
            end else if (ctlPtrWr) begin
                ptr_q <= ctlWrData & `CRH_PTR_WMASK;
            end else if ((ctlDataWr || ctlDataRd) && ptr_q[`CRH_PTR_STEP_BIT]) begin
                ptr_q[4:0] <= idx + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rsvd_q <= `CRH_RST_RSVD;
            clkMode_q <= `CRH_RST_CLKMODE;
            conv_q <= `CRH_RST_CONV;
            inCtl_q <= `CRH_RST_INCTL;
            auxCtl_q <= `CRH_RST_AUXCTL;
        end else if (ce) begin
            if (pdnLow) begin
                rsvd_q <= `CRH_RST_RSVD;
                clkMode_q <= `CRH_RST_CLKMODE;
                conv_q <= `CRH_RST_CONV;
                inCtl_q <= `CRH_RST_INCTL;
                auxCtl_q <= `CRH_RST_AUXCTL;
            end else if (dataWr) begin
                // Stand-by leaves all of these untouched
                case (idx)
                    `CRH_ADDR_RSVD: rsvd_q <= ctlWrData;
                    `CRH_ADDR_CLKMODE: clkMode_q <= ctlWrData & `CRH_CLKMODE_WMASK;
                    `CRH_ADDR_CONV: conv_q <= ctlWrData & `CRH_CONV_WMASK;
                    `CRH_ADDR_INCTL: inCtl_q <= ctlWrData;
                    `CRH_ADDR_AUXCTL: auxCtl_q <= ctlWrData & `CRH_AUX_WMASK;
                    default: ;
                endcase
            end
        end
    end

    // Hardware mute set wins over a software write in the same cycle
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            dacCtl_q <= `CRH_RST_DACCTL;
        end else if (ce) begin
            if (pdnLow) begin
                dacCtl_q <= `CRH_RST_DACCTL;
            end else if (holdEnd && autoMute_q && auxCtl_q[`CRH_AUX_AUTOUNMUTE_BIT]) begin
                dacCtl_q[5:0] <= `CRH_DAC_MUTE_ALL;
            end else if (dataWr && idx == `CRH_ADDR_DACCTL) begin
                dacCtl_q <= ctlWrData;
            end
        end
    end

    // ****************************************
    // Register read-back
    // ****************************************
    crh_byte_t convRd;
    crh_byte_t rdMux;
    always_comb begin
        convRd = conv_q;
        convRd[`CRH_CONV_TRIM_BIT] = calBusy;
        convRd[`CRH_CONV_CLKE_BIT] = clkFault || !pllLocked;
        convRd[`CRH_CONV_DU_BIT] = deemphOn_q;
        case (idx)
            `CRH_ADDR_RSVD: rdMux = rsvd_q;
            `CRH_ADDR_CLKMODE: rdMux = clkMode_q;
            `CRH_ADDR_CONV: rdMux = convRd;
            `CRH_ADDR_DACCTL: rdMux = dacCtl_q;
            `CRH_ADDR_INCTL: rdMux = inCtl_q;
            `CRH_ADDR_AUXCTL: rdMux = auxCtl_q;
            default: rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctlRdData_q <= 8'h00;
        end else if (ce && ctlDataRd) begin
            ctlRdData_q <= rdMux;
        end
    end

    // ****************************************
    // Clock supervision
    // ****************************************
    localparam int IW = $clog2(MCLK_LOSS_CYC + 1);
    localparam logic [IW-1:0] LOSS = IW'(MCLK_LOSS_CYC);
    logic [IW-1:0] idle_q;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            idle_q <= '0;
        end else if (ce) begin
            if (mclkEdge) begin
                idle_q <= '0;
            end else if (idle_q != LOSS) begin
                idle_q <= idle_q + 1'b1;
            end
        end
    end
    assign clkFault = (idle_q == LOSS) || !fsyncOk;

    // ****************************************
    // Core sequence and calibration
    // ****************************************
    crh_cal_if calLink ();
    crh_cal_timer #(.CAL_CYCLES(CAL_CYCLES)) u_cal (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .cal(calLink.tmr)
    );
    assign calBusy = calLink.busy;

    logic holdBit;
    logic calReqRise;
    logic modeChange;
    logic relock;
    logic calTrig;
    crh_state_t stateD;
    assign holdBit = conv_q[`CRH_CONV_HOLD_BIT];
    assign calReqRise = dataWr && idx == `CRH_ADDR_CONV
        && ctlWrData[`CRH_CONV_CALREQ_BIT] && !conv_q[`CRH_CONV_CALREQ_BIT];
    assign modeChange = dataWr && idx == `CRH_ADDR_CLKMODE
        && ctlWrData[4:0] != clkMode_q[4:0];
    assign relock = pllLocked && !lockPrev_q;
    assign calTrig = calReqRise || modeChange || relock;

    always_comb begin
        stateD = coreState_q;
        case (coreState_q)
            CRH_PWRDN: if (!pdnLow) stateD = CRH_HOLDRST;
            CRH_HOLDRST: if (!holdBit) stateD = CRH_CALIB;
            CRH_CALIB: begin
                if (holdBit) stateD = CRH_HOLDRST;
                else if (clkFault) stateD = CRH_STBY;
                else if (calLink.done) stateD = CRH_RUN;
            end
            CRH_RUN: begin
                if (holdBit) stateD = CRH_HOLDRST;
                else if (clkFault) stateD = CRH_STBY;
                else if (calTrig) stateD = CRH_CALIB;
            end
            CRH_STBY: begin
                if (holdBit) stateD = CRH_HOLDRST;
                else if (!clkFault) stateD = CRH_CALIB;
            end
            default: stateD = CRH_PWRDN;
        endcase
        if (pdnLow) stateD = CRH_PWRDN;
    end

    // A trigger during a running calibration restarts it
    assign calLink.start = ce && stateD == CRH_CALIB
        && (coreState_q != CRH_CALIB || calTrig);
    assign calLink.abort = ce && coreState_q == CRH_CALIB && stateD != CRH_CALIB;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            coreState_q <= CRH_PWRDN;
            commonModeEn_q <= 1'b0;
            coreRun_q <= 1'b0;
            standby_q <= 1'b0;
            loopCurrentHigh_q <= 1'b0;
        end else if (ce) begin
            coreState_q <= stateD;
            commonModeEn_q <= stateD != CRH_PWRDN && stateD != CRH_HOLDRST;
            coreRun_q <= stateD == CRH_RUN;
            standby_q <= stateD == CRH_STBY;
            loopCurrentHigh_q <= conv_q[`CRH_CONV_LOOPI_BIT];
        end
    end

    // ****************************************
    // De-emphasis selection
    // ****************************************
    logic [2:0] deSrc;
    logic deOn;
    assign deSrc = auxCtl_q[`CRH_AUX_SRC_MSB:0];
    always_comb begin
        if (deSrc <= `CRH_DEEMPH_SOFT_LAST) begin
            deOn = auxCtl_q[`CRH_AUX_SOFT_BIT];
        end else if (deSrc != `CRH_DEEMPH_CHSTAT) begin
            deOn = deemphIn;
        end else begin
            deOn = chStatEmphasis && clkMode_q[`CRH_CLKMODE_SRC_MSB:0] >= `CRH_SRC_RX_FIRST;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            deemphOn_q <= 1'b0;
            deemphRate_q <= `CRH_RATE_44K;
            deemphMask_q <= `CRH_MASK_ALL24;
        end else if (ce) begin
            deemphOn_q <= deOn;
            if (rxRateValid && rxRate != `CRH_RATE_RSVD) begin
                deemphRate_q <= rxRate;
            end else begin
                deemphRate_q <= `CRH_RATE_44K;
            end
            deemphMask_q <= auxCtl_q[`CRH_AUX_WIDTH_BIT] ? `CRH_MASK_AUDIO20
                                                         : `CRH_MASK_ALL24;
        end
    end

    // ****************************************
    // Sample hold and mute
    // ****************************************
    logic holdReq;
    logic holdSeen_q;
    logic [4:0] holdCount_q;
    localparam logic [4:0] MUTE_AT = 5'(HOLD_LIMIT + 1);
    assign holdReq = freezeIn
        || (parityErr && inCtl_q[`CRH_INCTL_PAR_BIT])
        || (biphaseErr && inCtl_q[`CRH_INCTL_BIPH_BIT])
        || (validityErr && inCtl_q[`CRH_INCTL_VALID_BIT]);
    assign holdEnd = frameEdge && sampleHold_q && !holdSeen_q && !holdReq;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            holdSeen_q <= 1'b0;
            sampleHold_q <= 1'b0;
            auxDiscard_q <= 1'b0;
            holdCount_q <= 5'h00;
        end else if (ce) begin
            // Any freeze seen in the frame carries to its end; set wins
            holdSeen_q <= holdReq || (holdSeen_q && !frameEdge);
            if (holdReq || (frameEdge && holdSeen_q)) begin
                sampleHold_q <= 1'b1;
                auxDiscard_q <= 1'b1;
            end else if (holdEnd) begin
                sampleHold_q <= 1'b0;
                auxDiscard_q <= 1'b0;
            end
            if (!sampleHold_q || holdEnd) begin
                holdCount_q <= 5'h00;
            end else if (frameEdge && holdCount_q != MUTE_AT) begin
                holdCount_q <= holdCount_q + 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            autoMute_q <= 1'b0;
            dacMute_q <= 6'h00;
        end else if (ce) begin
            if (holdEnd) begin
                autoMute_q <= 1'b0;
            end else if (holdCount_q == MUTE_AT && !auxCtl_q[`CRH_AUX_MUTEAFTER_BIT]) begin
                autoMute_q <= 1'b1;
            end
            dacMute_q <= dacCtl_q[5:0] | {6{autoMute_q}};
        end
    end

endmodule : crh_seq_top

// file: test/crh_host_model.sv
/* Host controller model driving the decoded control-port strobes.
   Assumes ref_clk from the bench; requests change on the falling edge. */
`timescale 1ns/100ps
module crh_host_model (
    // Clock
    input wire logic ref_clk,
    // Control port
    output logic ctlPtrWr,
    output logic ctlDataWr,
    output logic ctlDataRd,
    output logic [7:0] ctlWrData
);
    initial begin
        ctlPtrWr = 1'b0;
        ctlDataWr = 1'b0;
        ctlDataRd = 1'b0;
        ctlWrData = 8'h00;
    end

    // Kind 0 pointer, 1 write, 2 read; held across one rising edge
    task automatic xfer(input int k, input logic [7:0] d);
        @(negedge ref_clk);
        ctlPtrWr = (k == 0);
        ctlDataWr = (k == 1);
        ctlDataRd = (k == 2);
        ctlWrData = d;
        @(negedge ref_clk);
        ctlPtrWr = 1'b0;
        ctlDataWr = 1'b0;
        ctlDataRd = 1'b0;
        ctlWrData = ~d; // Released bus must not show a stale value
    endtask : xfer
endmodule : crh_host_model

// file: test/crh_seq_assertions.sv
/* Port checker of the sequencer top, bound into every instance.
   Assumes ce held high and a CAL_CYCLES matching the design. */
`timescale 1ns/100ps
module crh_seq_assertions #(
    parameter int CAL_CYCLES = 50
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic powerDownPinN,
    input wire logic frameSyncMatch,
    input wire logic freezePin,
    input wire logic ctlDataWr,
    input wire crh_pkg::crh_state_t coreState_q,
    input wire logic commonModeEn_q,
    input wire logic coreRun_q,
    input wire logic standby_q,
    input wire logic sampleHold_q,
    input wire logic auxDiscard_q
);
    import crh_pkg::*;
    int calCnt_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            calCnt_q <= 0;
        end else begin
            calCnt_q <= (coreState_q == CRH_CALIB) ? calCnt_q + 1 : 0;
        end
    end

    run_flag_a: assert property (coreRun_q == (coreState_q == CRH_RUN))
        else $error("run flag disagrees with state");
    cm_off_a: assert property (coreState_q inside {CRH_PWRDN, CRH_HOLDRST}
        |-> !commonModeEn_q) else $error("common mode on in reset");
    core_hold_a: assert property ($past(coreState_q) == CRH_HOLDRST
        && coreState_q == CRH_CALIB |-> $past(ctlDataWr, 2) || $past(ctlDataWr, 3)
        || $past(ctlDataWr, 4)) else $error("left hold without a write");
    cal_max_a: assert property (coreState_q == CRH_CALIB |-> calCnt_q <= CAL_CYCLES + 3)
        else $error("calibration too long");
    cal_min_a: assert property ($rose(coreRun_q) |-> calCnt_q >= CAL_CYCLES)
        else $error("calibration too short");
    standby_entry_a: assert property ($fell(frameSyncMatch) && coreRun_q
        |-> ##[1:8] standby_q) else $error("no stand-by on mismatch");
    freeze_hold_a: assert property ($rose(freezePin) |-> ##[1:6] sampleHold_q)
        else $error("freeze pin not holding");
    aux_discard_a: assert property (auxDiscard_q == sampleHold_q)
        else $error("aux discard differs from hold");
    pwrdn_force_a: assert property (!powerDownPinN [*4] |-> coreState_q == CRH_PWRDN)
        else $error("power-down pin ignored");

    cover property ($rose(coreRun_q));
    cover property ($rose(standby_q));
    cover property ($rose(sampleHold_q));
endmodule : crh_seq_assertions

bind crh_seq_top crh_seq_assertions #(.CAL_CYCLES(CAL_CYCLES)) chk (
    .ref_clk, .rstn, .powerDownPinN, .frameSyncMatch, .freezePin, .ctlDataWr,
    .coreState_q, .commonModeEn_q, .coreRun_q, .standby_q, .sampleHold_q, .auxDiscard_q
);

// file: test/tb_top.sv
/* Self-checking bench of the sequencer top with the host model.
   Assumes the bound checker; read results are queued and compared. */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
    import crh_pkg::*;
    localparam int CAL = 50;
    logic ref_clk = 0;
    logic rstn = 0;
    logic powerDownPinN = 1, masterClkPin = 0, frameSyncClock = 0, frameSyncMatch = 1;
    logic freezePin = 0, deemphPin = 0, parityErr = 0, rxRateValid = 0, mclkRun = 1;
    logic rdLag = 0, w, validityErr = 0;
    logic [1:0] rxRate = 0;
    logic [1:0] deemphRate_q;
    logic loopCurrentHigh_q, deemphOn_q;
    logic ctlPtrWr, ctlDataWr, ctlDataRd;
    crh_byte_t ctlWrData, ctlRdData_q, ev;
    crh_state_t coreState_q;
    logic commonModeEn_q, coreRun_q, standby_q, sampleHold_q, auxDiscard_q;
    logic [23:0] deemphMask_q;
    logic [5:0] dacMute_q;
    crh_byte_t expQ[$];
    int mismatches = 0, total_checks = 0, cyc = 0, seed = 40;

    crh_seq_top #(.CAL_CYCLES(CAL), .MCLK_LOSS_CYC(20)) dut (
        .ref_clk, .rstn, .ce(1'b1), .powerDownPinN, .masterClkPin, .frameSyncClock,
        .frameSyncMatch, .pllLockPin(1'b1), .freezePin, .deemphPin, .parityErr,
        .biphaseErr(1'b0), .validityErr, .chStatEmphasis(1'b0), .rxRate,
        .rxRateValid, .ctlPtrWr, .ctlDataWr, .ctlDataRd, .ctlWrData, .ctlRdData_q,
        .coreState_q, .commonModeEn_q, .coreRun_q, .standby_q, .loopCurrentHigh_q,
        .deemphOn_q, .deemphRate_q, .deemphMask_q, .sampleHold_q, .auxDiscard_q,
        .dacMute_q
    );
    crh_host_model host (.ref_clk, .ctlPtrWr, .ctlDataWr, .ctlDataRd, .ctlWrData);

    initial forever #12.5 ref_clk = ~ref_clk;

    always @(negedge ref_clk) begin
        cyc++;
        masterClkPin <= mclkRun ? ~masterClkPin : masterClkPin;
        frameSyncClock <= (cyc % 8) < 4;
        parityErr <= 1'($random(seed));
        deemphPin <= 1'($random(seed));
        rxRate <= 2'($random(seed));
        rxRateValid <= 1'($random(seed));
        validityErr <= 1'($random(seed));
        if (cyc > 16)
            `CHK("rate", rxRateValid && rxRate != 2'h2 ? rxRate : 2'h0, deemphRate_q)
        if (cyc > 20000) begin
            mismatches++;
            conclude();
        end
    end

    // Read data lands on the same rising edge that samples the strobe
    always @(posedge ref_clk) rdLag <= ctlDataRd;
    always @(negedge ref_clk) begin
        if (rdLag) begin
            ev = expQ.pop_front();
            `CHK("read data", ev, ctlRdData_q)
        end
    end

    task automatic rd(input crh_byte_t e);
        repeat (3) @(negedge ref_clk);
        expQ.push_back(e);
        host.xfer(2, 8'h00);
    endtask : rd

    task automatic waitRun();
        for (int i = 0; i < 300 && coreRun_q !== 1'b1; i++)
            @(negedge ref_clk);
        `CHK("run", 1'b1, coreRun_q)
    endtask : waitRun

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    initial begin
        repeat (12) @(negedge ref_clk);
        rstn = 1;
        repeat (6) @(negedge ref_clk);
        `CHK("state", CRH_HOLDRST, coreState_q)
        `CHK("cm", 1'b0, commonModeEn_q)
        host.xfer(0, 8'h80);
        rd(8'h00);
        rd(8'h01);
        rd(8'h01);
        rd(8'h3f);
        $display("defaults done");
        w = 1'($random(seed));
        host.xfer(0, 8'h03);
        host.xfer(1, 8'h00);
        host.xfer(0, 8'h0e);
        host.xfer(1, {3'h0, w, 4'h8});
        host.xfer(0, 8'h02);
        host.xfer(1, 8'h00);
        repeat (4) @(negedge ref_clk);
        `CHK("state", CRH_CALIB, coreState_q)
        rd(8'ha0);
        waitRun();
        `CHK("mask", w ? 24'hfffff0 : 24'hffffff, deemphMask_q)
        host.xfer(1, 8'h02);
        rd(8'ha2);
        waitRun();
        host.xfer(1, 8'h02);
        rd(8'h22);
        host.xfer(1, 8'h00);
        host.xfer(1, 8'h02);
        rd(8'ha2);
        waitRun();
        host.xfer(0, 8'h01);
        host.xfer(1, 8'h02);
        repeat (4) @(negedge ref_clk);
        `CHK("state", CRH_CALIB, coreState_q)
        waitRun();
        $display("calibration done");
        `CHK("hold", 1'b0, sampleHold_q)
        freezePin = 1;
        repeat (160) @(negedge ref_clk);
        `CHK("hold", 1'b1, sampleHold_q)
        `CHK("mute", 6'h3f, dacMute_q)
        freezePin = 0;
        repeat (32) @(negedge ref_clk);
        `CHK("hold", 1'b0, sampleHold_q)
        `CHK("mute", 6'h00, dacMute_q)
        $display("freeze done");
        for (int k = 0; k < 2; k++) begin
            if (k == 0)
                mclkRun = 0;
            else
                frameSyncMatch = 0;
            repeat (30) @(negedge ref_clk);
            `CHK("stby", 1'b1, standby_q)
            mclkRun = 1;
            frameSyncMatch = 1;
            waitRun();
        end
        $display("standby done");
        host.xfer(0, 8'h02);
        host.xfer(1, 8'h08);
        @(negedge ref_clk);
        `CHK("loop", 1'b1, loopCurrentHigh_q)
        `CHK("deemph", 1'b1, deemphOn_q)
        powerDownPinN = 0;
        repeat (6) @(negedge ref_clk);
        `CHK("state", CRH_PWRDN, coreState_q)
        `CHK("loop", 1'b0, loopCurrentHigh_q)
        powerDownPinN = 1;
        repeat (6) @(negedge ref_clk);
        host.xfer(0, 8'h03);
        rd(8'h3f);
        repeat (3) @(negedge ref_clk);
        $display("power-down done");
        conclude();
    end
endmodule : tb_top
